// ===== rtl/reference_clock_output.sv
// reference clock output generator: source select, power-of-two divider, duty shaping
`timescale 1ns/1ps
`include "refclk_map.svh"

// Function
// - source-select register picks which clock input feeds the generator
// - enabling waits for a base rising edge so the first pulse is whole
// - clearing enable forces the output low in the same cycle
// - three-bit ratio divides base clock by 1 up to 128
// - duty field gives 25, 50 or 75 percent on divided ratios only
// - duty field resets to binary 10, giving half-period duty
// - during sleep every generator state holds still, and the output too unless a control write changes enable
module reference_clock_output (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         nrst,
  // register port
  input  wire logic [`REFCLK_ADDR_W-1:0]    reg_addr,
  input  wire logic [`REFCLK_DATA_W-1:0]    reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [`REFCLK_DATA_W-1:0]    reg_rdata,
  // external clock sources, sampled as synchronous levels
  input  wire logic [`REFCLK_SRC_COUNT-2:0] src_clk_in,
  // power state
  input  wire logic                         sleep,
  // reference clock pin
  output logic                              refclk_out,
  output logic                              refclk_out_en
);

  refclk_pkg::bus_req_t   req;
  refclk_pkg::ctrl_t      ctrl_r;
  refclk_pkg::ctrl_t      ctrl_nxt;
  refclk_pkg::gen_state_t state_r;
  refclk_pkg::gen_state_t state_nxt;

  logic [`REFCLK_SRC_W-1:0]    src_sel_r;
  logic [`REFCLK_SRC_COUNT-1:0] src_lvl_r;
  logic                         base_r;
  logic                         base_prev_r;
  logic [`REFCLK_HALF_W-1:0]    half_r;
  logic [`REFCLK_HALF_W-1:0]    half_nxt;
  logic                         out_r;
  logic                         out_nxt;
  logic [`REFCLK_DATA_W-1:0]    rdata_r;
  logic [`REFCLK_DATA_W-1:0]    rdata_nxt;

  assign req.addr  = reg_addr;
  assign req.wdata = reg_wdata;
  assign req.wr    = reg_wr;
  assign req.rd    = reg_rd;

  // ---------------- register decode ----------------
  // a write lands at the edge that samples its strobe; the port never stalls
  wire wr_ctrl = req.wr && (req.addr == `REFCLK_OFS_CONTROL);
  wire wr_src  = req.wr && (req.addr == `REFCLK_OFS_SOURCE);

  // ratio and duty may be rewritten at any time
  // a change while running is taken as is; glitches then are the caller's risk
  assign ctrl_nxt = wr_ctrl ? refclk_pkg::ctrl_t'({req.wdata[`REFCLK_CTRL_EN_BIT], 2'h0,
                                                   req.wdata[`REFCLK_CTRL_DUTY_HI:`REFCLK_CTRL_DUTY_LO],
                                                   req.wdata[`REFCLK_CTRL_DIV_HI:`REFCLK_CTRL_DIV_LO]})
                            : ctrl_r;

  // control bits 6:5 are not stored and read back as zero
  wire [`REFCLK_DATA_W-1:0] ctrl_rd = {ctrl_r.en, 2'h0, ctrl_r.duty, ctrl_r.div};
  wire [`REFCLK_DATA_W-1:0] src_rd  = {{(`REFCLK_DATA_W-`REFCLK_SRC_W){1'b0}}, src_sel_r};
  // status shows the generator's own level, taken before the enable gate
  wire [`REFCLK_DATA_W-1:0] stat_rd = {5'h00, out_r,
                                       state_r == refclk_pkg::GEN_ARM,
                                       state_r == refclk_pkg::GEN_RUN};

  // read data stand for one cycle only, then fall back to zero
  // unmapped addresses read as zero
  assign rdata_nxt = !req.rd                             ? 8'h00 :
                     (req.addr == `REFCLK_OFS_CONTROL)   ? ctrl_rd :
                     (req.addr == `REFCLK_OFS_SOURCE)    ? src_rd :
                     (req.addr == `REFCLK_OFS_STATUS)    ? stat_rd :
                                                           8'h00;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      // duty resets to the half-period code
      ctrl_r    <= refclk_pkg::ctrl_t'(`REFCLK_CTRL_RESET);
      src_sel_r <= `REFCLK_SRC_RESET;
      rdata_r   <= 8'h00;
    end else begin
      ctrl_r    <= ctrl_nxt;
      src_sel_r <= wr_src ? req.wdata[`REFCLK_SRC_W-1:0] : src_sel_r;
      rdata_r   <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ---------------- clock sources ----------------
  // source 0 is the system clock halved: a clock cannot be sampled as data at its own rate
  // sources are frozen with the rest of the generator during sleep
  genvar gi;
  generate
    for (gi = 0; gi < `REFCLK_SRC_COUNT; gi = gi + 1) begin : g_src
      if (gi == 0) begin : g_self
        // internal source toggles every cycle, a period of two system cycles
        always_ff @(posedge ref_clk or negedge nrst) begin
          if (!nrst) begin
            src_lvl_r[gi] <= 1'b0;
          end else if (!sleep) begin
            src_lvl_r[gi] <= ~src_lvl_r[gi];
          end
        end
      end else begin : g_pin
        // pin sources are sampled once, so one edge cannot split across two readers
        always_ff @(posedge ref_clk or negedge nrst) begin
          if (!nrst) begin
            src_lvl_r[gi] <= 1'b0;
          end else if (!sleep) begin
            src_lvl_r[gi] <= src_clk_in[gi-1];
          end
        end
      end
    end
  endgenerate

  // base level follows the selected source
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      base_r      <= 1'b0;
      base_prev_r <= 1'b0;
    end else if (!sleep) begin
      base_r      <= src_lvl_r[src_sel_r];
      base_prev_r <= base_r;
    end
  end

  // both edge flops reset low, the idle level, so no false rise follows reset
  // a source must be no faster than half the system clock, the rate of source 0, or its edges alias
  wire base_rise = base_r && !base_prev_r;
  wire base_edge = base_r != base_prev_r;

  // ---------------- divider and duty ----------------
  // half_r counts base half-periods; ratio 2^n spans 2^(n+1) of them,
  // so bits n and n-1 give the quarter of the output period
  // ratio 0 wraps the shift amount; harmless, since run_lvl then takes base_r
  // the counter wraps at 256 half-periods, one full period of the slowest ratio
  // ratio picks which counter bits form the phase
  wire [`REFCLK_HALF_W-1:0] half_shift = half_nxt >> (ctrl_r.div - 3'h1);
  wire [1:0]                quarter    = half_shift[1:0];

  // duty compare on the quarter index
  wire duty_hi = (ctrl_r.duty == refclk_pkg::DUTY_25) ? (quarter == 2'h0) :
                 (ctrl_r.duty == refclk_pkg::DUTY_50) ? (quarter <  2'h2) :
                 (ctrl_r.duty == refclk_pkg::DUTY_75) ? (quarter <  2'h3) :
                                                        1'b0;

  // undivided ratio passes the base level with its own duty
  wire run_lvl = (ctrl_r.div == 3'h0) ? base_r : duty_hi;

  // state and phase counter; the output level is derived apart from them so the
  // phase lookup never feeds back into the process that computes the phase
  always_comb begin
    state_nxt = state_r;
    half_nxt  = half_r;
    unique case (state_r)
      refclk_pkg::GEN_IDLE: begin
        if (ctrl_r.en) begin
          state_nxt = refclk_pkg::GEN_ARM;
        end
      end
      // start only on a base rising edge, phase zero
      refclk_pkg::GEN_ARM: begin
        if (!ctrl_r.en) begin
          state_nxt = refclk_pkg::GEN_IDLE;
        end else if (base_rise) begin
          state_nxt = refclk_pkg::GEN_RUN;
          half_nxt  = '0;
        end
      end
      refclk_pkg::GEN_RUN: begin
        if (!ctrl_r.en) begin
          state_nxt = refclk_pkg::GEN_IDLE;
          half_nxt  = '0;
        end else if (base_edge) begin
          half_nxt = half_r + 8'h01;
        end
      end
      // the fourth code is unused; fall back to idle
      default: begin
        state_nxt = refclk_pkg::GEN_IDLE;
        half_nxt  = '0;
      end
    endcase
  end

  // output stays low until the first whole pulse and drops on disable
  wire start_now = (state_r == refclk_pkg::GEN_ARM) && ctrl_r.en && base_rise;
  wire run_now   = (state_r == refclk_pkg::GEN_RUN) && ctrl_r.en;
  assign out_nxt = (start_now || run_now) ? run_lvl : 1'b0;

  // the register port is not gated by sleep, only the generator is
  // sleep holds state, counter and output level
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= refclk_pkg::GEN_IDLE;
      half_r  <= '0;
      out_r   <= 1'b0;
    end else if (!sleep) begin
      state_r <= state_nxt;
      half_r  <= half_nxt;
      out_r   <= out_nxt;
    end
  end

  // the pin enable follows the register bit, so a stopped pin is released
  // enable gates the pin directly so disable acts at once
  assign refclk_out    = out_r & ctrl_r.en;
  assign refclk_out_en = ctrl_r.en;

endmodule // reference_clock_output

// ===== shared/refclk_map.svh
// register offsets, field positions and reset values of the reference clock output
`ifndef REFCLK_MAP_SVH
`define REFCLK_MAP_SVH

`define REFCLK_ADDR_W          4
`define REFCLK_DATA_W          8

`define REFCLK_OFS_CONTROL     4'h0
`define REFCLK_OFS_SOURCE      4'h1
`define REFCLK_OFS_STATUS      4'h2

`define REFCLK_CTRL_EN_BIT     7
`define REFCLK_CTRL_DUTY_HI    4
`define REFCLK_CTRL_DUTY_LO    3
`define REFCLK_CTRL_DIV_HI     2
`define REFCLK_CTRL_DIV_LO     0
`define REFCLK_CTRL_RESET      8'h10

`define REFCLK_SRC_W           2
`define REFCLK_SRC_COUNT       4
`define REFCLK_SRC_RESET       2'h0

`define REFCLK_STAT_RUN_BIT    0
`define REFCLK_STAT_ARM_BIT    1
`define REFCLK_STAT_OUT_BIT    2

`define REFCLK_HALF_W          8

`endif

// ===== shared/refclk_pkg.sv
// types shared by the reference clock output generator
package refclk_pkg;

  typedef enum logic [1:0] {
    DUTY_OFF = 2'h0,
    DUTY_25  = 2'h1,
    DUTY_50  = 2'h2,
    DUTY_75  = 2'h3
  } duty_t;

  typedef struct packed {
    logic        en;
    logic [1:0]  pad;
    duty_t       duty;
    logic [2:0]  div;
  } ctrl_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef enum logic [1:0] {
    GEN_IDLE,
    GEN_ARM,
    GEN_RUN
  } gen_state_t;

endpackage

// ===== tb/refclk_chk_sva.sv
// port assertions for the reference clock output
`timescale 1ns/1ps
module refclk_chk (
  // clock
  input wire logic       ref_clk,
  input wire logic       nrst,
  // registers
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // pins
  input wire logic [2:0] src_clk_in,
  input wire logic       sleep,
  input wire logic       refclk_out,
  input wire logic       refclk_out_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire ctl_wr = reg_wr && reg_addr == 4'h0;
  wire src_wr = reg_wr && reg_addr == 4'h1;
  sequence ctl_back; ctl_wr ##1 reg_rd && reg_addr == 4'h0; endsequence
  sequence src_back; src_wr ##1 reg_rd && reg_addr == 4'h1; endsequence
  chk_ctl_read: assert property (ctl_back |=> reg_rdata == ($past(reg_wdata, 2) & 8'h9f))
    else $error("control readback");
  chk_src_read: assert property (src_back |=> reg_rdata == ($past(reg_wdata, 2) & 8'h03))
    else $error("source readback");
  chk_gap_read: assert property (reg_rd && reg_addr > 4'h2 |=> reg_rdata == 8'h0)
    else $error("unmapped read");
  chk_rd_quiet: assert property (!reg_rd |=> reg_rdata == 8'h0)
    else $error("stray read data");
  chk_en_pin: assert property (ctl_wr |=> refclk_out_en == $past(reg_wdata[7]))
    else $error("enable pin");
  chk_off_stop: assert property (ctl_wr && !reg_wdata[7] |=> !refclk_out)
    else $error("late stop");
  chk_off_low: assert property (!refclk_out_en |-> !refclk_out)
    else $error("output while off");
  chk_sleep_hold: assert property (sleep && !reg_wr |=> $stable(refclk_out))
    else $error("output moved in sleep");
endmodule // refclk_chk

bind reference_clock_output refclk_chk refclk_chk_inst (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .src_clk_in, .sleep, .refclk_out, .refclk_out_en);

// ===== tb/refclk_sink.sv
// clock consumer that measures high time and period
`timescale 1ns/1ps
module refclk_sink (
  // clock
  input wire logic   ref_clk,
  input wire logic   nrst,
  // observed pin
  input wire logic   refclk_out,
  input wire logic   refclk_out_en,
  // widths in system cycles
  output logic [9:0] hi_len,
  output logic [9:0] per_len
);
  logic       prev_r;
  logic [9:0] hi_r;
  logic [9:0] per_r;
  // cleared while undriven so a runt first pulse cannot hide behind old widths
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst || !refclk_out_en) begin
      prev_r <= 1'b0;
      hi_r <= 10'h0;
      per_r <= 10'h0;
      hi_len <= 10'h0;
      per_len <= 10'h0;
    end else begin
      prev_r <= refclk_out;
      hi_r <= refclk_out ? hi_r + 10'h1 : 10'h0;
      per_r <= (refclk_out && !prev_r) ? 10'h1 : per_r + 10'h1;
      if (!refclk_out && prev_r) hi_len <= hi_r;
      if (refclk_out && !prev_r && hi_len != 10'h0) per_len <= per_r;
    end
  end
endmodule // refclk_sink

// ===== tb/reference_clock_output_tb.sv
// self-checking bench for the reference clock output
`timescale 1ns/1ps
module reference_clock_output_tb;
  logic ref_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, sleep = 0, refclk_out, refclk_out_en;
  logic [3:0] reg_addr = 4'h0, tick_r = 4'h0;
  logic [7:0] reg_wdata = 8'h0, reg_rdata;
  logic [2:0] src_clk_in = 3'h0;
  logic [9:0] hi_len, per_len;
  int fail_count = 0, compares = 0;
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    tick_r <= tick_r + 4'h1;
    src_clk_in <= tick_r[3:1];
  end
  reference_clock_output reference_clock_output_inst (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .src_clk_in, .sleep, .refclk_out, .refclk_out_en);
  refclk_sink refclk_sink_inst (.ref_clk, .nrst, .refclk_out, .refclk_out_en, .hi_len, .per_len);
  task automatic chk(input logic [9:0] s, input logic [9:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  task automatic idle(input int n);
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic go(input logic [7:0] d, input int n);
    acc(1'b1, 4'h0, d);
    idle(n);
  endtask
  task automatic wait_out(input logic v);
    int n;
    for (n = 0; n < 600 && refclk_out !== v; n++) @(posedge ref_clk) #1;
    if (n == 600) begin
      chk(10'h0, 10'h1);
      final_report();
    end
  endtask
  task automatic t_regs();
    acc(1'b0, 4'h0, 8'h0);
    idle(0);
    chk({2'h0, reg_rdata}, 10'h10);
    acc(1'b0, 4'h3, 8'h0);
    idle(0);
    chk({2'h0, reg_rdata}, 10'h0);
    acc(1'b1, 4'h1, 8'hff);
    acc(1'b0, 4'h1, 8'h0);
    idle(0);
    chk({2'h0, reg_rdata}, 10'h3);
    acc(1'b1, 4'h0, 8'h7f);
    acc(1'b0, 4'h0, 8'h0);
    idle(0);
    chk({2'h0, reg_rdata}, 10'h1f);
    acc(1'b1, 4'h1, 8'h0);
    idle(0);
    $display("done regs");
  endtask
  task automatic t_ratio();
    for (int d = 0; d < 8; d++)
      for (int k = 1; k < 4; k++) begin
        // new ratio and duty only while disabled
        go({5'h0, d[2:0]}, 0);
        go({1'b1, 2'h0, k[1:0], d[2:0]}, (6 << d) + 8);
        chk(per_len, 10'h2 << d);
        chk(hi_len, d == 0 ? 10'h1 : k[9:0] << (d - 1));
      end
    $display("done ratio");
  endtask
  task automatic t_src();
    for (int s = 1; s < 4; s++) begin
      go(8'h10, 0);
      acc(1'b1, 4'h1, s[7:0]);
      idle(0);
      go(8'h90, 60);
      chk(per_len, 10'h2 << s);
      chk(hi_len, 10'h1 << s);
    end
    go(8'h10, 0);
    acc(1'b1, 4'h1, 8'h0);
    idle(0);
    $display("done source");
  endtask
  task automatic t_stop();
    go(8'h01, 0);
    go(8'h81, 20);
    chk(hi_len, 10'h0);
    chk({9'h0, refclk_out_en}, 10'h1);
    go(8'h1a, 0);
    go(8'h9a, 0);
    wait_out(1'b1);
    wait_out(1'b0);
    // the sink latches the width one edge after the fall
    @(posedge ref_clk) #1;
    chk(hi_len, 10'h6);
    wait_out(1'b1);
    go(8'h1a, 0);
    chk({9'h0, refclk_out}, 10'h0);
    chk({9'h0, refclk_out_en}, 10'h0);
    go(8'h1b, 0);
    go(8'h9b, 0);
    wait_out(1'b1);
    @(posedge ref_clk);
    sleep <= 1'b1;
    // frozen high in its second cycle; running on, it would now sit in its low quarter
    repeat (13) @(posedge ref_clk);
    sleep <= 1'b0;
    #1;
    chk({9'h0, refclk_out}, 10'h1);
    $display("done stop");
  endtask
  task automatic final_report();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    t_regs();
    t_ratio();
    t_src();
    t_stop();
    final_report();
  end
endmodule // reference_clock_output_tb
